// ### core/amsc_pkg.sv
package amsc_pkg;
   // Register indices as printed; byte address is four times the index.
   localparam logic [7:0]  STEP_SIX_IDX    = 8'h96;
   localparam logic [7:0]  STEP_SEVEN_IDX  = 8'h97;
   localparam logic [11:0] STEP_SIX_ADDR   = {2'b00, STEP_SIX_IDX, 2'b00};
   localparam logic [11:0] STEP_SEVEN_ADDR = {2'b00, STEP_SEVEN_IDX, 2'b00};
   localparam int          EN_BIT          = 15;
   localparam int          GAIN_HI         = 14;
   localparam int          GAIN_LO         = 13;
   localparam int          NEG_BIT         = 4;
   localparam int          POS_HI          = 3;
   localparam logic [15:0] STEP_SIX_RESET  = 16'h0006;
   localparam logic [15:0] STEP_SEVEN_RESET = 16'h0007;
   localparam logic [15:0] STEP_WMASK      = 16'he01f;
   localparam logic [3:0]  POS_INTERNAL    = 4'h8;
   localparam logic [1:0]  AXI_OKAY        = 2'b00;
   localparam logic [1:0]  AXI_SLVERR      = 2'b10;
   typedef enum logic [1:0] {AMSC_GAIN_1, AMSC_GAIN_2, AMSC_GAIN_4} amsc_gain_t;
   typedef enum logic [1:0] {AMSC_NEG_GROUND, AMSC_NEG_INPUT_SEVEN,
                             AMSC_NEG_AUTO} amsc_neg_t;
endpackage : amsc_pkg

// ### core/amsc_step_config.sv
// Operation
// [RULE_01] Bit 15 includes the step in the sequencer when set.
// [RULE_02] Gain bits 14:13: 00 gain 1, 01 gain 2, 10/11 gain 4.
// [RULE_03] Bit 4 picks negative input: ground reference or input seven.
// [RULE_04] Positive codes 0000 to 0111 route external inputs zero to seven.
// [RULE_05] Positive codes 1000 and above pick internal sources.
// [RULE_06] Internal source makes negative input automatic; bit 4 ignored.
// [RULE_07] Reset: disabled, gain 00, negative 0, positive equals step number.
// [RULE_08] Next step register sits at 97h, resets to 0007h.
// [RULE_09] Bits 12:5 read zero, writes there have no effect.
// [RULE_10] Only an enabled step applies its gain and input selections.
`timescale 1ns/10ps
`default_nettype none
module amsc_step_config (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 step_select,
   output logic                      step_enable,
   output amsc_pkg::amsc_gain_t      step_gain_select,
   output amsc_pkg::amsc_neg_t       step_negative_input_select,
   output logic [3:0]                step_positive_input_select
);
   import amsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] six_reg, six_next, seven_reg, seven_next;
   logic        aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next;
   logic [11:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next;
   logic [3:0]  ws_reg, ws_next;
   logic [1:0]  br_reg, br_next;
   logic        rv_reg, rv_next;
   logic        awrdy_reg, awrdy_next, wrdy_reg, wrdy_next;
   logic        arrdy_reg, arrdy_next;
   logic [31:0] rd_reg, rd_next;
   logic [1:0]  rr_reg, rr_next;
   logic        en_reg, en_next;
   amsc_gain_t  g_reg, g_next;
   amsc_neg_t   n_reg, n_next;
   logic [3:0]  p_reg, p_next;
   logic        sel_m_reg, sel_reg;

   // Byte-lane merge; reserved bits never store.
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  st);
      logic [15:0] v;
      v = old;
      if (st[0]) begin
         v[7:0] = d[7:0];
      end
      if (st[1]) begin
         v[15:8] = d[15:8];
      end
      return v & STEP_WMASK; // see [RULE_09]
   endfunction : merge

   function automatic logic mapped(input logic [11:0] a);
      return (a == STEP_SIX_ADDR) || (a == STEP_SEVEN_ADDR);
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////////
   // Write path: address and data taken in either order.
   always_comb begin
      aw_next  = aw_reg;
      w_next   = w_reg;
      awa_next = awa_reg;
      wd_next  = wd_reg;
      ws_next  = ws_reg;
      bv_next  = bv_reg;
      br_next  = br_reg;
      six_next = six_reg;
      seven_next = seven_reg;
      if (s_axi_awvalid && !aw_reg) begin
         aw_next  = 1'b1;
         awa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_reg) begin
         w_next  = 1'b1;
         wd_next = s_axi_wdata;
         ws_next = s_axi_wstrb;
      end
      if (bv_reg && s_axi_bready) begin
         bv_next = 1'b0;
      end
      if (aw_reg && w_reg && !bv_reg) begin
         aw_next = 1'b0;
         w_next  = 1'b0;
         bv_next = 1'b1;
         br_next = mapped(awa_reg) ? AXI_OKAY : AXI_SLVERR;
         if (awa_reg == STEP_SIX_ADDR) begin
            six_next = merge(six_reg, wd_reg, ws_reg);
         end
         if (awa_reg == STEP_SEVEN_ADDR) begin
            seven_next = merge(seven_reg, wd_reg, ws_reg); // see [RULE_08]
         end
      end
      // Readies are registered so that every bus output leaves a flop.
      awrdy_next = !aw_next;
      wrdy_next  = !w_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg    <= 1'b0;
         w_reg     <= 1'b0;
         awa_reg   <= '0;
         wd_reg    <= '0;
         ws_reg    <= '0;
         bv_reg    <= 1'b0;
         br_reg    <= AXI_OKAY;
         six_reg   <= STEP_SIX_RESET; // see [RULE_07]
         seven_reg <= STEP_SEVEN_RESET; // see [RULE_08]
         awrdy_reg <= 1'b1;
         wrdy_reg  <= 1'b1;
      end else begin
         aw_reg    <= aw_next;
         w_reg     <= w_next;
         awa_reg   <= awa_next;
         wd_reg    <= wd_next;
         ws_reg    <= ws_next;
         bv_reg    <= bv_next;
         br_reg    <= br_next;
         six_reg   <= six_next;
         seven_reg <= seven_next;
         awrdy_reg <= awrdy_next;
         wrdy_reg  <= wrdy_next;
      end
   end

   assign s_axi_awready = awrdy_reg;
   assign s_axi_wready  = wrdy_reg;
   assign s_axi_bvalid  = bv_reg;
   assign s_axi_bresp   = br_reg;

   ////////////////////////////////////////////////////////////////////////
   // Read path: one cycle from address to data.
   always_comb begin
      rv_next = rv_reg;
      rd_next = rd_reg;
      rr_next = rr_reg;
      if (rv_reg && s_axi_rready) begin
         rv_next = 1'b0;
      end
      if (s_axi_arvalid && !rv_reg) begin
         rv_next = 1'b1;
         rr_next = mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
         if (s_axi_araddr == STEP_SIX_ADDR) begin
            rd_next = {16'h0000, six_reg}; // see [RULE_09]
         end else if (s_axi_araddr == STEP_SEVEN_ADDR) begin
            rd_next = {16'h0000, seven_reg};
         end else begin
            rd_next = '0;
         end
      end
      arrdy_next = !rv_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rv_reg <= 1'b0;
         rd_reg <= '0;
         rr_reg <= AXI_OKAY;
         arrdy_reg <= 1'b1;
      end else begin
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         rr_reg <= rr_next;
         arrdy_reg <= arrdy_next;
      end
   end

   assign s_axi_arready = arrdy_reg;
   assign s_axi_rvalid  = rv_reg;
   assign s_axi_rdata   = rd_reg;
   assign s_axi_rresp   = rr_reg;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer-facing outputs for the step currently being converted.
   amsc_step_if six_if ();
   amsc_step_if seven_if ();
   assign six_if.cfg   = six_reg;
   assign seven_if.cfg = seven_reg;

   amsc_step_decode u_six (
      .s (six_if)
   );
   amsc_step_decode u_seven (
      .s (seven_if)
   );

   always_comb begin
      if (sel_reg) begin
         en_next = seven_if.active;
         g_next  = seven_if.gain;
         n_next  = seven_if.neg;
         p_next  = seven_if.pos;
      end else begin
         en_next = six_if.active;
         g_next  = six_if.gain;
         n_next  = six_if.neg;
         p_next  = six_if.pos;
      end
      // A disabled step is skipped, so its selections are held back.
      if (!en_next) begin // see [RULE_10]
         g_next = AMSC_GAIN_1;
         n_next = AMSC_NEG_GROUND;
         p_next = '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_m_reg <= 1'b0;
         sel_reg   <= 1'b0;
         en_reg    <= 1'b0;
         g_reg     <= AMSC_GAIN_1;
         n_reg     <= AMSC_NEG_GROUND;
         p_reg     <= '0;
      end else begin
         sel_m_reg <= step_select;
         sel_reg   <= sel_m_reg;
         en_reg    <= en_next;
         g_reg     <= g_next;
         n_reg     <= n_next;
         p_reg     <= p_next;
      end
   end

   assign step_enable                = en_reg;
   assign step_gain_select           = g_reg;
   assign step_negative_input_select = n_reg;
   assign step_positive_input_select = p_reg;
endmodule : amsc_step_config
`default_nettype wire

// ### core/amsc_step_decode.sv
`timescale 1ns/10ps
`default_nettype none
module amsc_step_decode (
   amsc_step_if.dec s
);
   import amsc_pkg::*;
   always_comb begin
      s.active = s.cfg[EN_BIT]; // see [RULE_01]
      case (s.cfg[GAIN_HI:GAIN_LO]) // see [RULE_02]
         2'b00:   s.gain = AMSC_GAIN_1;
         2'b01:   s.gain = AMSC_GAIN_2;
         default: s.gain = AMSC_GAIN_4;
      endcase
      s.pos = s.cfg[POS_HI:0]; // see [RULE_04] see [RULE_05]
      if (s.pos >= POS_INTERNAL) begin
         s.neg = AMSC_NEG_AUTO; // see [RULE_06]
      end else if (s.cfg[NEG_BIT]) begin
         s.neg = AMSC_NEG_INPUT_SEVEN; // see [RULE_03]
      end else begin
         s.neg = AMSC_NEG_GROUND;
      end
   end
endmodule : amsc_step_decode
`default_nettype wire

// ### core/amsc_step_if.sv
`timescale 1ns/10ps
`default_nettype none
interface amsc_step_if;
   logic [15:0] cfg;
   logic        active;
   amsc_pkg::amsc_gain_t gain;
   amsc_pkg::amsc_neg_t  neg;
   logic [3:0]  pos;
   modport src (output cfg, input active, gain, neg, pos);
   modport dec (input cfg, output active, gain, neg, pos);
endinterface : amsc_step_if
`default_nettype wire

// ### verif/amsc_step_config_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module amsc_step_config_assertions (
   input wire logic                 aclk,
   input wire logic                 aresetn,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_rvalid,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic                 step_enable,
   input wire amsc_pkg::amsc_gain_t step_gain_select,
   input wire amsc_pkg::amsc_neg_t  step_negative_input_select,
   input wire logic [3:0]           step_positive_input_select
);
   import amsc_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_off; !step_enable |-> {step_gain_select,
      step_negative_input_select, step_positive_input_select} == 8'h00;
   endproperty
   a_off: assert property (p_off)
      else $error("disabled step leaks");
   property p_gain; step_gain_select != 2'h3; endproperty
   a_gain: assert property (p_gain)
      else $error("bad gain code");
   property p_auto; step_enable && step_positive_input_select[3]
      |-> step_negative_input_select == AMSC_NEG_AUTO; endproperty
   a_auto: assert property (p_auto)
      else $error("no auto negative");
   property p_ext; step_enable && !step_positive_input_select[3]
      |-> step_negative_input_select != AMSC_NEG_AUTO; endproperty
   a_ext: assert property (p_ext)
      else $error("auto on external");
   property p_resv; s_axi_rvalid
      |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[12:5] == 8'h00;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved bits set");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat)
      else $error("read answer late");
   property p_one; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_one: assert property (p_one)
      else $error("second read taken");
   property p_rst; $rose(aresetn)
      |-> !step_enable && !s_axi_bvalid && !s_axi_rvalid; endproperty
   a_rst: assert property (p_rst)
      else $error("reset state wrong");
endmodule : amsc_step_config_assertions
bind amsc_step_config amsc_step_config_assertions u_chk (
   .aclk                       (aclk),
   .aresetn                    (aresetn),
   .s_axi_arvalid              (s_axi_arvalid),
   .s_axi_arready              (s_axi_arready),
   .s_axi_bvalid               (s_axi_bvalid),
   .s_axi_rvalid               (s_axi_rvalid),
   .s_axi_rdata                (s_axi_rdata),
   .step_enable                (step_enable),
   .step_gain_select           (step_gain_select),
   .step_negative_input_select (step_negative_input_select),
   .step_positive_input_select (step_positive_input_select)
);
`default_nettype wire

// ### verif/tb_adc_seq_step_config.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_seq_step_config;
   import amsc_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, step_select = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'h3, step_positive_input_select;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, step_enable;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   amsc_gain_t step_gain_select;
   amsc_neg_t step_negative_input_select;
   int bad_count = 0, check_count = 0, cyc = 0;
   amsc_step_config dut (
      .aclk                       (aclk),
      .aresetn                    (aresetn),
      .s_axi_awaddr               (s_axi_awaddr),
      .s_axi_awvalid              (s_axi_awvalid),
      .s_axi_awready              (s_axi_awready),
      .s_axi_wdata                (s_axi_wdata),
      .s_axi_wstrb                (s_axi_wstrb),
      .s_axi_wvalid               (s_axi_wvalid),
      .s_axi_wready               (s_axi_wready),
      .s_axi_bresp                (s_axi_bresp),
      .s_axi_bvalid               (s_axi_bvalid),
      .s_axi_bready               (s_axi_bready),
      .s_axi_araddr               (s_axi_araddr),
      .s_axi_arvalid              (s_axi_arvalid),
      .s_axi_arready              (s_axi_arready),
      .s_axi_rdata                (s_axi_rdata),
      .s_axi_rresp                (s_axi_rresp),
      .s_axi_rvalid               (s_axi_rvalid),
      .s_axi_rready               (s_axi_rready),
      .step_select                (step_select),
      .step_enable                (step_enable),
      .step_gain_select           (step_gain_select),
      .step_negative_input_select (step_negative_input_select),
      .step_positive_input_select (step_positive_input_select)
   );
   always #4 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [15:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, v};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd
   // Outputs settle one cycle after the write, plus two for the select.
   task automatic outs(input logic [8:0] e);
      repeat (8) @(posedge aclk);
      @(negedge aclk);
      chk({23'h0, step_enable, step_gain_select,
           step_negative_input_select, step_positive_input_select}, {23'h0, e});
   endtask : outs
   task automatic t_reset;
      rd(STEP_SIX_ADDR);
      chk(d, 32'h0000_0006);
      rd(STEP_SEVEN_ADDR);
      chk(d, 32'h0000_0007);
      chk({30'h0, r}, 32'h0);
      outs(9'h000);
      $display("reset test done");
   endtask : t_reset
   task automatic t_bad;
      wr(12'h254, 16'hffff);
      chk({30'h0, r}, 32'h2);
      rd(12'h254);
      chk(d, 32'h0);
      chk({30'h0, r}, 32'h2);
      $display("unmapped test done");
   endtask : t_bad
   task automatic t_resv;
      wr(STEP_SEVEN_ADDR, 16'hffff);
      rd(STEP_SEVEN_ADDR);
      chk(d, 32'h0000_e01f);
      @(posedge aclk);
      step_select <= 1'h1;
      outs({1'h1, 2'h2, 2'h2, 4'hf});
      @(posedge aclk);
      step_select <= 1'h0;
      $display("reserved test done");
   endtask : t_resv
   task automatic t_gain;
      for (int g = 0; g < 4; g++) begin
         wr(STEP_SIX_ADDR, {1'h1, 2'(g), 13'h0000});
         outs({1'h1, (g > 1) ? 2'h2 : 2'(g),
               6'h00});
      end
      $display("gain test done");
   endtask : t_gain
   task automatic t_pos;
      for (int c = 0; c < 16; c++) begin
         wr(STEP_SIX_ADDR, {1'h1, 10'h000, 1'h1, 4'(c)});
         outs({3'h4, (c > 7) ? 2'h2 : 2'h1,
               4'(c)});
      end
      $display("input test done");
   endtask : t_pos
   task automatic t_off;
      wr(STEP_SIX_ADDR, 16'h2013);
      outs(9'h000);
      rd(STEP_SIX_ADDR);
      chk(d, 32'h0000_2013);
      $display("disable test done");
   endtask : t_off
   // Each strobe lane must update only its own byte of the register.
   task automatic t_strb;
      @(posedge aclk);
      s_axi_wstrb <= 4'h1;
      wr(STEP_SIX_ADDR, 16'hffff);
      chk({30'h0, r}, 32'h0);
      s_axi_wstrb <= 4'h2;
      rd(STEP_SIX_ADDR);
      chk(d, 32'h0000_201f);
      wr(STEP_SIX_ADDR, 16'h0000);
      s_axi_wstrb <= 4'h3;
      rd(STEP_SIX_ADDR);
      chk(d, 32'h0000_001f);
      $display("strobe test done");
   endtask : t_strb
   // A reset in mid-run must restore both registers after writes.
   task automatic t_rerst;
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(STEP_SIX_ADDR);
      chk(d, 32'h0000_0006);
      rd(STEP_SEVEN_ADDR);
      chk(d, 32'h0000_0007);
      $display("second reset test done");
   endtask : t_rerst
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_bad();
      t_resv();
      t_gain();
      t_pos();
      t_off();
      t_strb();
      t_rerst();
      summarize();
   end
endmodule : tb_adc_seq_step_config
`default_nettype wire
